/* File: hdl/smsr_regs.sv */
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
module smsr_regs
(
    input  wire logic                          clk,              // system clock, 100 MHz
    input  wire logic                          reset_n,          // system reset, any cause
    input  wire logic                          por_n,            // power-on reset only
    input  wire logic                          wb_cyc_i,         // bus cycle
    input  wire logic                          wb_stb_i,         // bus strobe
    input  wire logic                          wb_we_i,          // write enable
    input  wire logic [smsr_pkg::ADR_W-1:0]    wb_adr_i,         // byte address
    input  wire logic [3:0]                    wb_sel_i,         // byte lanes
    input  wire logic [smsr_pkg::DAT_W-1:0]    wb_dat_i,         // write data
    output logic      [smsr_pkg::DAT_W-1:0]    wb_dat_o,         // read data
    output logic                               wb_ack_o,         // acknowledge
    input  wire logic                          warn_detector_raw,// warning comparator
    input  wire logic                          lowv_below_raw,   // lowvolt comparator
    input  wire logic                          lowv_enabled,     // lowvolt option on
    input  wire logic                          ext_clock_sel,    // external clock chosen
    input  wire logic                          ext_clock_fast,   // external clock > 10 MHz
    input  wire logic                          halt_mode,        // device in halt
    input  wire logic                          irq_service_entry,// warning vector taken
    output logic      [1:0]                    warning_level_field, // to warning detector
    output logic      [1:0]                    rc_trim_low_bits, // to rc oscillator
    output logic      [2:0]                    rc_prescale_select,  // to rc prescaler
    output logic                               irq,              // interrupt level
    output logic                               wake_req          // wake request
);

    // ------------------------------------------------------------------------
    // detector synchronisation
    // ------------------------------------------------------------------------
    smsr_det_if det ();

    smsr_detect_sync u_sync
    (
        .clk      (clk),
        .por_n    (por_n),
        .warn_raw (warn_detector_raw),
        .lowv_raw (lowv_below_raw),
        .det      (det)
    );

    function automatic logic hit(input logic [smsr_pkg::ADR_W-1:0] adr, input logic [7:0] idx);
        hit = (adr[smsr_pkg::ADR_W-1:smsr_pkg::IDX_LSB] == idx);
    endfunction

    // ------------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------------
    logic                         req;
    logic                         wr_now;
    logic                         rd_now;
    logic [smsr_pkg::REG_W-1:0]   wdat;
    logic                         voltage_warning_irq_enable;
    logic                         voltage_warning_flag;
    logic                         lowvolt_reset_flag;
    logic [smsr_pkg::IRQ_W-1:0]   irq_status;
    logic [smsr_pkg::IRQ_W-1:0]   irq_mask;
    logic [smsr_pkg::REG_W-1:0]   next_rdata;

    assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_now = req & wb_we_i & wb_sel_i[0];
    assign rd_now = req & ~wb_we_i;
    assign wdat   = wb_dat_i[smsr_pkg::REG_W-1:0];

    always_comb
    begin
        next_rdata = '0;
        if (hit(wb_adr_i, smsr_pkg::IDX_CTRL_STATUS))
        begin
            next_rdata[smsr_pkg::CS_IRQ_EN] = voltage_warning_irq_enable;
            next_rdata[smsr_pkg::CS_WARN]   = voltage_warning_flag;
            next_rdata[smsr_pkg::CS_LV_FLAG] = lowvolt_reset_flag;
            next_rdata[smsr_pkg::CS_TRIM_LSB +: smsr_pkg::CS_TRIM_W] = rc_trim_low_bits;
        end
        else if (hit(wb_adr_i, smsr_pkg::IDX_THRESHOLD))
        begin
            next_rdata[smsr_pkg::TH_LEVEL_LSB +: smsr_pkg::TH_LEVEL_W] = warning_level_field;
            next_rdata[smsr_pkg::TH_PRESC_LSB +: smsr_pkg::TH_PRESC_W] = rc_prescale_select;
        end
        else if (hit(wb_adr_i, smsr_pkg::IDX_IRQ_STATUS))
        begin
            next_rdata[smsr_pkg::IRQ_W-1:0] = irq_status;
        end
        else if (hit(wb_adr_i, smsr_pkg::IDX_IRQ_MASK))
        begin
            next_rdata[smsr_pkg::IRQ_W-1:0] = irq_mask;
        end
    end

    // unmapped addresses are acknowledged and read as zero
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= req;
            if (rd_now)
            begin
                wb_dat_o <= {{(smsr_pkg::DAT_W-smsr_pkg::REG_W){1'b0}}, next_rdata};
            end
        end
    end

    // ------------------------------------------------------------------------
    // ctrl/status register (frozen in halt, except the lowvolt flag)
    // ------------------------------------------------------------------------
    logic ctrl_wr;
    logic warn_active;
    logic warn_cross;

    assign ctrl_wr     = wr_now & hit(wb_adr_i, smsr_pkg::IDX_CTRL_STATUS) & ~halt_mode;
    assign warn_active = det.warn_lvl & (warning_level_field != smsr_pkg::LEVEL_OFF);
    assign warn_cross  = ~halt_mode & (warn_active != voltage_warning_flag);

    // reserved bits 7 and 4:3 are not stored and read zero
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            voltage_warning_irq_enable <= 1'b0;
            rc_trim_low_bits           <= smsr_pkg::TRIM_RESET;
        end
        else if (ctrl_wr)
        begin
            voltage_warning_irq_enable <= wdat[smsr_pkg::CS_IRQ_EN];
            rc_trim_low_bits <= wdat[smsr_pkg::CS_TRIM_LSB +: smsr_pkg::CS_TRIM_W];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            voltage_warning_flag <= 1'b0;
        end
        else if (!halt_mode)
        begin
            voltage_warning_flag <= warn_active;
        end
    end

    // ------------------------------------------------------------------------
    // threshold select register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            warning_level_field <= smsr_pkg::LEVEL_RESET;
            rc_prescale_select  <= smsr_pkg::PRESC_RESET;
        end
        else if (wr_now && hit(wb_adr_i, smsr_pkg::IDX_THRESHOLD))
        begin
            warning_level_field <= wdat[smsr_pkg::TH_LEVEL_LSB +: smsr_pkg::TH_LEVEL_W];
            rc_prescale_select  <= wdat[smsr_pkg::TH_PRESC_LSB +: smsr_pkg::TH_PRESC_W];
        end
    end

    // ------------------------------------------------------------------------
    // lowvolt dip qualification, survives every reset but power-on
    // ------------------------------------------------------------------------
    smsr_pkg::smsr_lv_state_type lv_state;
    logic [smsr_pkg::DIP_CNT_W-1:0] dip_cnt;
    logic                           dip_in_halt;
    logic                           long_dip;
    logic                           lv_set;

    assign long_dip = (dip_cnt >= smsr_pkg::DIP_CNT_W'(smsr_pkg::LOWRC_CYCLES));

    always_comb
    begin
        lv_set = 1'b0;
        if (lv_state == smsr_pkg::LV_BELOW && det.lowv_fall && lowv_enabled)
        begin
            if (ext_clock_sel)
            begin
                lv_set = ~dip_in_halt & ext_clock_fast;
            end
            else
            begin
                lv_set = long_dip;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!por_n)
        begin
            lv_state    <= smsr_pkg::LV_IDLE;
            dip_cnt     <= '0;
            dip_in_halt <= 1'b0;
        end
        else
        begin
            case (lv_state)
                smsr_pkg::LV_IDLE:
                begin
                    if (det.lowv_rise)
                    begin
                        lv_state    <= smsr_pkg::LV_BELOW;
                        dip_cnt     <= '0;
                        dip_in_halt <= halt_mode;
                    end
                end
                smsr_pkg::LV_BELOW:
                begin
                    if (det.lowv_fall)
                    begin
                        lv_state <= smsr_pkg::LV_IDLE;
                    end
                    else if (!long_dip)
                    begin
                        dip_cnt <= dip_cnt + 1'b1;
                    end
                end
                default:
                begin
                    lv_state <= smsr_pkg::LV_IDLE;
                end
            endcase
        end
    end

    // power-on and a ctrl/status read clear it; reset_n (external, watchdog) does not
    always_ff @(posedge clk)
    begin
        if (!por_n)
        begin
            lowvolt_reset_flag <= 1'b0;
        end
        else if (lv_set)
        begin
            lowvolt_reset_flag <= 1'b1;
        end
        else if (reset_n && rd_now && hit(wb_adr_i, smsr_pkg::IDX_CTRL_STATUS))
        begin
            lowvolt_reset_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // interrupt status, mask and outputs
    // ------------------------------------------------------------------------
    logic [smsr_pkg::IRQ_W-1:0] irq_set;
    logic [smsr_pkg::IRQ_W-1:0] irq_clr;

    always_comb
    begin
        irq_set = '0;
        irq_set[smsr_pkg::IRQ_WARN]  = warn_cross & voltage_warning_irq_enable;
        irq_set[smsr_pkg::IRQ_LVRST] = lv_set;
        irq_clr = '0;
        if (wr_now && hit(wb_adr_i, smsr_pkg::IDX_IRQ_STATUS))
        begin
            irq_clr = wdat[smsr_pkg::IRQ_W-1:0];
        end
        irq_clr[smsr_pkg::IRQ_WARN] = irq_clr[smsr_pkg::IRQ_WARN] | irq_service_entry;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            irq_status <= smsr_pkg::IRQ_RESET;
        end
        else
        begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            irq_mask <= smsr_pkg::IRQ_RESET;
        end
        else if (wr_now && hit(wb_adr_i, smsr_pkg::IDX_IRQ_MASK))
        begin
            irq_mask <= wdat[smsr_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            irq      <= 1'b0;
            wake_req <= 1'b0;
        end
        else
        begin
            irq      <= |(irq_status & irq_mask);
            wake_req <= |(irq_status & irq_mask) & ~halt_mode;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    a_ack_single_pulse : assert property (@(posedge clk) disable iff (!reset_n)
        req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");
    a_warn_follows_det : assert property (@(posedge clk) disable iff (!reset_n)
        (!halt_mode && warning_level_field != smsr_pkg::LEVEL_OFF) |=>
        voltage_warning_flag == $past(det.warn_lvl)) else $error("warning flag lags detector");
    a_warn_level_off : assert property (@(posedge clk) disable iff (!reset_n)
        (!halt_mode && warning_level_field == smsr_pkg::LEVEL_OFF) |=>
        !voltage_warning_flag) else $error("warning flag set with detector off");
    a_cross_raises_irq : assert property (@(posedge clk) disable iff (!reset_n)
        (warn_cross && voltage_warning_irq_enable) |=> irq_status[smsr_pkg::IRQ_WARN])
        else $error("crossing lost");
    a_no_req_disabled : assert property (@(posedge clk) disable iff (!reset_n)
        $rose(irq_status[smsr_pkg::IRQ_WARN]) |-> $past(voltage_warning_irq_enable))
        else $error("request raised while disabled");
    a_service_clears : assert property (@(posedge clk) disable iff (!reset_n)
        (irq_service_entry && !irq_set[smsr_pkg::IRQ_WARN]) |=>
        !irq_status[smsr_pkg::IRQ_WARN]) else $error("service entry did not clear");
    a_halt_frozen : assert property (@(posedge clk) disable iff (!reset_n)
        (halt_mode && $past(halt_mode) && $past(reset_n)) |->
        $stable(voltage_warning_flag) && $stable(voltage_warning_irq_enable) && !wake_req)
        else $error("ctrl/status changed in halt");
    a_read_clears_flag : assert property (@(posedge clk) disable iff (!reset_n)
        (rd_now && hit(wb_adr_i, smsr_pkg::IDX_CTRL_STATUS) && !lv_set) |=>
        !lowvolt_reset_flag) else $error("lowvolt flag not cleared by read");
    a_flag_survives_rst : assert property (@(posedge clk) disable iff (!por_n)
        (!reset_n && lowvolt_reset_flag) |=> lowvolt_reset_flag)
        else $error("lowvolt flag lost in reset");
    a_short_dip_ignored : assert property (@(posedge clk) disable iff (!por_n)
        (lv_set && !ext_clock_sel) |-> dip_cnt >= smsr_pkg::DIP_CNT_W'(smsr_pkg::LOWRC_CYCLES))
        else $error("short dip recorded");
    a_ext_halt_never : assert property (@(posedge clk) disable iff (!por_n)
        (lv_set && ext_clock_sel) |-> !dip_in_halt && ext_clock_fast)
        else $error("lowvolt flag set under external clock rule");
    a_thr_reset_value : assert property (@(posedge clk)
        !reset_n |=> warning_level_field == smsr_pkg::LEVEL_RESET && !voltage_warning_irq_enable)
        else $error("reset values wrong");

endmodule

/* File: hdl/smsr_pkg.sv */
// ----------------------------------------------------------------------------
// shared constants of the supply monitor status registers
// ----------------------------------------------------------------------------
package smsr_pkg;

    // register word indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_STATUS = 8'h3a;
    localparam logic [7:0] IDX_THRESHOLD   = 8'h3e;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'h40;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'h41;

    localparam int ADR_W   = 10;
    localparam int DAT_W   = 32;
    localparam int REG_W   = 8;
    localparam int IDX_LSB = 2;

    // supply_monitor_ctrl_status fields
    localparam int CS_IRQ_EN   = 0;
    localparam int CS_WARN     = 1;
    localparam int CS_LV_FLAG  = 2;
    localparam int CS_TRIM_LSB = 5;
    localparam int CS_TRIM_W   = 2;

    // warning_threshold_select fields
    localparam int TH_LEVEL_LSB = 0;
    localparam int TH_LEVEL_W   = 2;
    localparam int TH_PRESC_LSB = 5;
    localparam int TH_PRESC_W   = 3;

    // interrupt status / mask bits
    localparam int IRQ_W      = 2;
    localparam int IRQ_WARN   = 0;
    localparam int IRQ_LVRST  = 1;

    localparam logic [1:0] TRIM_RESET   = 2'h0;
    localparam logic [1:0] LEVEL_RESET  = 2'h3;
    localparam logic [2:0] PRESC_RESET  = 3'h0;
    localparam logic [1:0] LEVEL_LOW    = 2'h0;
    localparam logic [1:0] LEVEL_MEDIUM = 2'h1;
    localparam logic [1:0] LEVEL_HIGH   = 2'h2;
    localparam logic [1:0] LEVEL_OFF    = 2'h3;
    localparam logic [1:0] IRQ_RESET    = 2'h0;

    // low-power rc period that a dip must last to be recorded while ext_clock_sel is low
    localparam int CLK_PERIOD_NS   = 10;
    localparam int LOWRC_PERIOD_NS = 33000;
    localparam int LOWRC_CYCLES    = (LOWRC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIP_CNT_W       = 12;

    typedef enum logic
    {
        LV_IDLE  = 1'b0,
        LV_BELOW = 1'b1
    } smsr_lv_state_type;

endpackage

/* File: hdl/smsr_det_if.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// synchronised detector levels and lowvolt edges
// ----------------------------------------------------------------------------
interface smsr_det_if;
    logic warn_lvl;
    logic lowv_lvl;
    logic lowv_rise;
    logic lowv_fall;

    modport source
    (
        output warn_lvl,
        output lowv_lvl,
        output lowv_rise,
        output lowv_fall
    );

    modport sink
    (
        input warn_lvl,
        input lowv_lvl,
        input lowv_rise,
        input lowv_fall
    );
endinterface

/* File: hdl/smsr_detect_sync.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// two-stage synchronisers for the analog detector outputs
// ----------------------------------------------------------------------------
module smsr_detect_sync
(
    input  wire logic        clk,          // system clock
    input  wire logic        por_n,        // power-on reset, active low
    input  wire logic        warn_raw,     // asynchronous warning comparator
    input  wire logic        lowv_raw,     // asynchronous lowvolt comparator
    smsr_det_if.source       det           // synchronised levels and edges
);

    logic [1:0] warn_sync;
    logic [1:0] lowv_sync;
    logic       lowv_last;

    always_ff @(posedge clk)
    begin
        if (!por_n)
        begin
            warn_sync <= 2'h0;
            lowv_sync <= 2'h0;
            lowv_last <= 1'b0;
        end
        else
        begin
            warn_sync <= {warn_sync[0], warn_raw};
            lowv_sync <= {lowv_sync[0], lowv_raw};
            lowv_last <= lowv_sync[1];
        end
    end

    assign det.warn_lvl = warn_sync[1];
    assign det.lowv_lvl  = lowv_sync[1];
    assign det.lowv_rise = lowv_sync[1] & ~lowv_last;
    assign det.lowv_fall = ~lowv_sync[1] & lowv_last;

    a_sync_two_stage : assert property (@(posedge clk) disable iff (!por_n)
        $past(warn_raw, 2) == warn_sync[1]) else $error("warning not delayed two stages");

endmodule

/* File: testbench/test_supply_monitor_status_regs.sv */
`timescale 1ns/100ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_supply_monitor_status_regs;
    localparam logic [9:0] A_CS   = {smsr_pkg::IDX_CTRL_STATUS, 2'h0};
    localparam logic [9:0] A_TH   = {smsr_pkg::IDX_THRESHOLD, 2'h0};
    localparam logic [9:0] A_IRQ  = {smsr_pkg::IDX_IRQ_STATUS, 2'h0};
    localparam logic [9:0] A_MASK = {smsr_pkg::IDX_IRQ_MASK, 2'h0};
    logic        clk = 1'b0, reset_n = 1'b0, por_n = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [9:0]  wb_adr_i = 10'h000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, irq, wake_req;
    logic        warn_detector_raw = 1'b0, lowv_below_raw = 1'b0, lowv_enabled = 1'b1;
    logic        ext_clock_sel = 1'b0, ext_clock_fast = 1'b0;
    logic        halt_mode = 1'b0, irq_service_entry = 1'b0;
    logic [1:0]  warning_level_field, rc_trim_low_bits;
    logic [2:0]  rc_prescale_select;
    int          num_errors = 0, comparisons = 0;

    smsr_regs dut
    (
        .clk(clk), .reset_n(reset_n), .por_n(por_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .warn_detector_raw(warn_detector_raw), .lowv_below_raw(lowv_below_raw),
        .lowv_enabled(lowv_enabled), .ext_clock_sel(ext_clock_sel),
        .ext_clock_fast(ext_clock_fast), .halt_mode(halt_mode),
        .irq_service_entry(irq_service_entry), .warning_level_field(warning_level_field),
        .rc_trim_low_bits(rc_trim_low_bits), .rc_prescale_select(rc_prescale_select),
        .irq(irq), .wake_req(wake_req)
    );

    initial
    begin
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------------
    // bus cycles; every task starts and ends just after a rising edge
    // ------------------------------------------------------------------------
    task automatic wb(input logic we, input logic [9:0] adr, input logic [7:0] wd,
                      output logic [7:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, wd};
        do
        begin
            @(posedge clk);
        end
        while (wb_ack_o !== 1'b1);
        `CHECK(wb_ack_o, 1'b1)
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [9:0] adr, input logic [7:0] wd);
        logic [7:0] rd;
        wb(1'b1, adr, wd, rd);
    endtask

    task automatic rd_chk(input logic [9:0] adr, input logic [7:0] exp);
        logic [7:0] rd;
        wb(1'b0, adr, 8'h00, rd);
        `CHECK(rd, exp)
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic test_done();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        rd_chk(A_CS, 8'h00);
        rd_chk(A_TH, 8'h03);
        `CHECK(warning_level_field, smsr_pkg::LEVEL_OFF)
    endtask

    task automatic t_fields();
        for (int i = 0; i < 4; i++)
        begin
            wr(A_TH, {3'h5, 3'h0, 2'(i)});
            `CHECK(warning_level_field, 2'(i))
            rd_chk(A_TH, {3'h5, 3'h0, 2'(i)});
        end
        `CHECK(rc_prescale_select, 3'h5)
        wr(A_CS, 8'h60);
        `CHECK(rc_trim_low_bits, 2'h3)
        rd_chk(A_CS, 8'h60);
        rd_chk(10'h3fc, 8'h00);
    endtask

    task automatic t_warn();
        wr(A_TH, 8'h00);
        wr(A_MASK, 8'h01);
        wr(A_CS, 8'h01);
        warn_detector_raw <= 1'b1;
        wait_clk(6);
        rd_chk(A_CS, 8'h03);
        `CHECK(irq, 1'b1)
        irq_service_entry <= 1'b1;
        wait_clk(1);
        irq_service_entry <= 1'b0;
        wait_clk(3);
        `CHECK(irq, 1'b0)
        warn_detector_raw <= 1'b0;
        wait_clk(6);
        rd_chk(A_IRQ, 8'h01);
        wr(A_IRQ, 8'h01);
        `CHECK(irq, 1'b0)
        wr(A_CS, 8'h00);
        warn_detector_raw <= 1'b1;
        wait_clk(6);
        rd_chk(A_IRQ, 8'h00);
        wr(A_TH, 8'h03);
        rd_chk(A_CS, 8'h00);
        halt_mode <= 1'b1;
        wr(A_CS, 8'h01);
        rd_chk(A_CS, 8'h00);
        halt_mode <= 1'b0;
        warn_detector_raw <= 1'b0;
    endtask

    // one lowvolt dip of n clocks, then time for the synchroniser
    task automatic dip(input int n, input logic ext, input logic fast, input logic halt);
        ext_clock_sel  <= ext;
        ext_clock_fast <= fast;
        halt_mode      <= halt;
        lowv_below_raw <= 1'b1;
        wait_clk(n);
        lowv_below_raw <= 1'b0;
        wait_clk(6);
        halt_mode      <= 1'b0;
        wait_clk(1);
    endtask

    task automatic t_lowvolt();
        dip(3290, 1'b0, 1'b0, 1'b0);
        rd_chk(A_CS, 8'h00);
        dip(3310, 1'b0, 1'b0, 1'b0);
        reset_n <= 1'b0;
        wait_clk(10);
        reset_n <= 1'b1;
        wait_clk(1);
        rd_chk(A_CS, 8'h04);
        rd_chk(A_CS, 8'h00);
        dip(20, 1'b1, 1'b1, 1'b0);
        rd_chk(A_IRQ, 8'h02);
        wr(A_MASK, 8'h02);
        `CHECK(wake_req, 1'b1)
        halt_mode <= 1'b1;
        wait_clk(2);
        `CHECK(wake_req, 1'b0)
        `CHECK(irq, 1'b1)
        halt_mode <= 1'b0;
        rd_chk(A_CS, 8'h04);
        dip(20, 1'b1, 1'b0, 1'b0);
        rd_chk(A_CS, 8'h00);
        dip(20, 1'b1, 1'b1, 1'b1);
        rd_chk(A_CS, 8'h00);
        lowv_enabled <= 1'b0;
        dip(20, 1'b1, 1'b1, 1'b0);
        lowv_enabled <= 1'b1;
        rd_chk(A_CS, 8'h00);
    endtask

    initial
    begin
        #400000;
        num_errors++;
        test_done();
    end

    initial
    begin
        wait_clk(10);
        reset_n <= 1'b1;
        por_n   <= 1'b1;
        wait_clk(1);
        t_reset();
        t_fields();
        t_warn();
        t_lowvolt();
        test_done();
    end
endmodule
